/* include/air_defs.vh */
// Register offsets, field positions, reset values and select codes.
`ifndef AIR_DEFS_VH
`define AIR_DEFS_VH

`define AIR_ADDR_W            8
`define AIR_DATA_W            8
`define AIR_CODE_W            6

`define AIR_CHAN_SEL_ADDR     8'hBB
`define AIR_REF_CTRL_ADDR     8'hD1

`define AIR_CHAN_SEL_RESET    6'h3F
`define AIR_REF_CTRL_RESET    4'h0
`define AIR_CHAN_SEL_MASK     8'h3F
`define AIR_REF_CTRL_MASK     8'h0F

`define AIR_BIT_REF_BUF_EN    0
`define AIR_BIT_BIAS_EN       1
`define AIR_BIT_TEMP_EN       2
`define AIR_BIT_REF_SRC_SEL   3

`define AIR_CODE_LAST_PIN     6'h1F
`define AIR_CODE_RSVD_LO      6'h20
`define AIR_CODE_RSVD_HI      6'h2F
`define AIR_CODE_TEMP         6'h30
`define AIR_CODE_SUPPLY       6'h31
`define AIR_CODE_GND_LO       6'h32

`define AIR_PIN_COUNT         32

`endif

/* core/air_src_decode.v */
// Decoder from the positive input code to one-hot source selects.
`include "air_defs.vh"

module air_src_decode #(
  parameter PIN_COUNT = `AIR_PIN_COUNT
) (
  input  wire [`AIR_CODE_W-1:0] i_code,
  output reg  [31:0]            o_pin_sel,
  output reg                    o_temp_sel,
  output reg                    o_supply_sel,
  output reg                    o_gnd_sel,
  output reg                    o_invalid
);

  always @*
  begin
    o_pin_sel    = 32'h0000_0000;
    o_temp_sel   = 1'b0;
    o_supply_sel = 1'b0;
    o_gnd_sel    = 1'b0;
    o_invalid    = 1'b0;
    if (i_code <= `AIR_CODE_LAST_PIN)
    begin
      if ({26'h000_0000, i_code} < PIN_COUNT)
        o_pin_sel[i_code[4:0]] = 1'b1;
      else
        o_invalid = 1'b1;
    end
    else if (i_code <= `AIR_CODE_RSVD_HI)
      o_invalid = 1'b1;
    else if (i_code == `AIR_CODE_TEMP)
      o_temp_sel = 1'b1;
    else if (i_code == `AIR_CODE_SUPPLY)
      o_supply_sel = 1'b1;
    else
      o_gnd_sel = 1'b1;
  end

endmodule // air_src_decode

/* core/air_ctrl_top.v */
// Converter input multiplexer and reference control register bank.
//
// Overview of operation
// - Six-bit code routes pins 0-31, temperature sensor (48), supply (49) or ground (50-63).
// - Temperature sensor reaches the converter only through the multiplexer.
// - Temperature enable bit turns the sensor on or off.
// - Disabled sensor output floats; conversions from it are flagged invalid.
// - Reference select: 0 uses reference pin, 1 uses supply.
// - Bias enable bit switches on the shared bias generator.
// - Bias generator also turns on when any needing peripheral is enabled.
// - Reference buffer enable drives the on-chip reference onto the pin.
`include "air_defs.vh"

module air_ctrl_top #(
  parameter PIN_COUNT = `AIR_PIN_COUNT
) (
  input  wire                   i_clk_sys,
  input  wire                   i_resetn,
  input  wire [`AIR_ADDR_W-1:0] i_sfr_addr,
  input  wire [`AIR_DATA_W-1:0] i_sfr_wdata,
  input  wire                   i_sfr_wr,
  input  wire                   i_sfr_rd,
  output reg  [`AIR_DATA_W-1:0] o_sfr_rdata,
  input  wire                   i_conv_enable,
  input  wire                   i_osc_bias_req,
  input  wire                   i_periph_bias_req,
  output reg  [31:0]            o_pin_select,
  output reg                    o_temp_select,
  output reg                    o_supply_select,
  output reg                    o_ground_select,
  output reg                    o_select_invalid,
  output reg                    o_temp_sensor_on,
  output reg                    o_temp_sensor_hiz,
  output reg                    o_temp_reading_invalid,
  output reg                    o_ref_from_supply,
  output reg                    o_ref_from_pin,
  output reg                    o_ref_buffer_drive,
  output reg                    o_bias_on,
  output reg                    o_channel_changed
);

  reg  [`AIR_CODE_W-1:0] chan_code_q;
  reg  [`AIR_CODE_W-1:0] chan_code_d;
  reg  [3:0]             ref_ctrl_q;
  reg  [3:0]             ref_ctrl_d;
  reg  [`AIR_DATA_W-1:0] rdata_d;
  wire                   chan_hit;
  wire                   ref_hit;
  wire [31:0]            dec_pin_sel;
  wire                   dec_temp_sel;
  wire                   dec_supply_sel;
  wire                   dec_gnd_sel;
  wire                   dec_invalid;
  wire                   temp_en;
  wire                   bias_manual;
  wire                   ref_src_supply;
  wire                   ref_buf_en;
  wire                   bias_needed;

  assign chan_hit       = (i_sfr_addr == `AIR_CHAN_SEL_ADDR);
  assign ref_hit        = (i_sfr_addr == `AIR_REF_CTRL_ADDR);
  assign temp_en        = ref_ctrl_q[`AIR_BIT_TEMP_EN];
  assign bias_manual    = ref_ctrl_q[`AIR_BIT_BIAS_EN];
  assign ref_src_supply = ref_ctrl_q[`AIR_BIT_REF_SRC_SEL];
  assign ref_buf_en     = ref_ctrl_q[`AIR_BIT_REF_BUF_EN];

  // Write decode for the channel select register.
  always @*
  begin
    chan_code_d = chan_code_q;
    if (i_sfr_wr && chan_hit)
      chan_code_d = i_sfr_wdata[`AIR_CODE_W-1:0];
  end

  // Write decode for the reference control register.
  always @*
  begin
    ref_ctrl_d = ref_ctrl_q;
    if (i_sfr_wr && ref_hit)
      ref_ctrl_d = i_sfr_wdata[3:0];
  end

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      chan_code_q <= `AIR_CHAN_SEL_RESET;
      ref_ctrl_q  <= `AIR_REF_CTRL_RESET;
    end
    else
    begin
      chan_code_q <= chan_code_d;
      ref_ctrl_q  <= ref_ctrl_d;
    end
  end

  // Read data is captured on the read strobe; unmapped addresses read zero.
  always @*
  begin
    rdata_d = 8'h00;
    if (chan_hit)
      rdata_d = {2'b00, chan_code_q};
    else if (ref_hit)
      rdata_d = {4'h0, ref_ctrl_q};
    else
      rdata_d = 8'h00;
  end

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_sfr_rdata <= 8'h00;
    else if (i_sfr_rd)
      o_sfr_rdata <= rdata_d;
  end

  air_src_decode #(
    .PIN_COUNT (PIN_COUNT)
  ) u_src_decode (
    .i_code       (chan_code_q),
    .o_pin_sel    (dec_pin_sel),
    .o_temp_sel   (dec_temp_sel),
    .o_supply_sel (dec_supply_sel),
    .o_gnd_sel    (dec_gnd_sel),
    .o_invalid    (dec_invalid)
  );

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_pin_select     <= 32'h0000_0000;
      o_supply_select  <= 1'b0;
      o_ground_select  <= 1'b1;
      o_select_invalid <= 1'b0;
    end
    else
    begin
      o_pin_select     <= dec_pin_sel;
      o_supply_select  <= dec_supply_sel;
      o_ground_select  <= dec_gnd_sel;
      o_select_invalid <= dec_invalid;
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_temp_select <= 1'b0;
    else
      o_temp_select <= dec_temp_sel;
  end

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_temp_sensor_on <= 1'b0;
    else
      o_temp_sensor_on <= temp_en;
  end

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_temp_sensor_hiz      <= 1'b1;
      o_temp_reading_invalid <= 1'b0;
    end
    else
    begin
      o_temp_sensor_hiz      <= ~temp_en;
      o_temp_reading_invalid <= dec_temp_sel & ~temp_en;
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ref_from_supply <= 1'b0;
      o_ref_from_pin    <= 1'b1;
    end
    else
    begin
      o_ref_from_supply <= ref_src_supply;
      o_ref_from_pin    <= ~ref_src_supply;
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_ref_buffer_drive <= 1'b0;
    else
      o_ref_buffer_drive <= ref_buf_en;
  end

  assign bias_needed = i_conv_enable | i_osc_bias_req | i_periph_bias_req |
                       temp_en;

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_bias_on <= 1'b0;
    else
      o_bias_on <= bias_manual | bias_needed;
  end

  // One-cycle pulse when the stored channel code changes, so the converter
  // can restart its settling time.
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_channel_changed <= 1'b0;
    else
      o_channel_changed <= (chan_code_d != chan_code_q);
  end

endmodule // air_ctrl_top

/* test/air_ctrl_sva.sv */
// Concurrent checks on the input select and reference control ports.
`include "air_defs.vh"
module air_ctrl_sva (
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic        i_sfr_wr,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic        i_conv_enable,
  input wire logic        i_osc_bias_req,
  input wire logic        i_periph_bias_req,
  input wire logic [31:0] o_pin_select,
  input wire logic        o_temp_select,
  input wire logic        o_supply_select,
  input wire logic        o_ground_select,
  input wire logic        o_select_invalid,
  input wire logic        o_temp_sensor_on,
  input wire logic        o_temp_sensor_hiz,
  input wire logic        o_temp_reading_invalid,
  input wire logic        o_ref_from_supply,
  input wire logic        o_ref_from_pin,
  input wire logic        o_ref_buffer_drive,
  input wire logic        o_bias_on
);
  wire [5:0] c = i_sfr_wdata[5:0];
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  sequence s_chan_wr;
    i_sfr_wr && i_sfr_addr == `AIR_CHAN_SEL_ADDR;
  endsequence
  sequence s_ref_wr;
    i_sfr_wr && i_sfr_addr == `AIR_REF_CTRL_ADDR;
  endsequence
  a_pin_route: assert property (s_chan_wr ##0 c < 6'h20 |-> ##2
    o_pin_select == 32'h0000_0001 << $past(c, 2)) else $error("pin route");
  a_temp_route: assert property (s_chan_wr ##0 c == 6'h30 |-> ##2
    o_temp_select && !o_ground_select) else $error("temp route");
  a_supply_route: assert property (s_chan_wr ##0 c == 6'h31 |-> ##2
    o_supply_select && o_pin_select == 0) else $error("supply route");
  a_gnd_route: assert property (s_chan_wr ##0 c >= 6'h32 |-> ##2
    o_ground_select && !o_select_invalid) else $error("ground route");
  a_rsvd_code: assert property (s_chan_wr ##0 c[5:4] == 2'b10 |-> ##2
    o_select_invalid && !o_ground_select) else $error("reserved code");
  a_sensor_enable: assert property (s_ref_wr |-> ##2
    o_temp_sensor_on == $past(i_sfr_wdata[2], 2) &&
    o_temp_sensor_hiz != o_temp_sensor_on) else $error("sensor enable");
  a_ref_source: assert property (s_ref_wr |-> ##2
    o_ref_from_supply == $past(i_sfr_wdata[3], 2) &&
    o_ref_from_pin != o_ref_from_supply) else $error("ref source");
  a_ref_buffer: assert property (s_ref_wr |-> ##2
    o_ref_buffer_drive == $past(i_sfr_wdata[0], 2)) else $error("buffer");
  a_bias_manual: assert property (s_ref_wr ##0 i_sfr_wdata[1] |-> ##2
    o_bias_on) else $error("bias manual");
  a_bias_auto: assert property (i_conv_enable || i_osc_bias_req ||
    i_periph_bias_req |=> o_bias_on) else $error("bias auto");
  a_temp_invalid: assert property (o_temp_reading_invalid ==
    (o_temp_select && !o_temp_sensor_on)) else $error("temp invalid");
  a_read_mask: assert property (i_sfr_rd && i_sfr_addr == 8'hBB |=>
    o_sfr_rdata[7:6] == 2'b00) else $error("read mask");
endmodule // air_ctrl_sva

/* test/tb.sv */
// Self-checking bench for the input select and reference control bank.
`include "air_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 0, i_resetn = 0, i_sfr_wr = 0, i_sfr_rd = 0;
  logic i_conv_enable = 0, i_osc_bias_req = 0, i_periph_bias_req = 0;
  logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, o_sfr_rdata;
  logic [31:0] o_pin_select;
  logic o_temp_select, o_supply_select, o_ground_select, o_select_invalid;
  logic o_temp_sensor_on, o_temp_sensor_hiz, o_temp_reading_invalid;
  logic o_ref_from_supply, o_ref_from_pin, o_ref_buffer_drive, o_bias_on;
  logic o_channel_changed;
  logic [31:0] lfsr_q = 32'h0000_4414;
  int fail_count = 0, samples_checked = 0, cycles = 0, chg_count = 0;
  air_ctrl_top i_dut (.*);
  always #4 i_clk_sys = ~i_clk_sys;
  // Counts channel-change pulses where they are settled.
  always @(negedge i_clk_sys)
  begin
    if (o_channel_changed === 1'b1)
      chg_count++;
  end
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      summarize();
    end
  end
  function automatic logic [31:0] next_rand();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  // Expected {pins, temp, supply, ground, invalid} for one select code.
  function automatic logic [35:0] exp_route(logic [5:0] c);
    exp_route = '0;
    if (c < 6'h20) exp_route[35:4] = 32'h0000_0001 << c;
    exp_route[3] = c == 6'h30;
    exp_route[2] = c == 6'h31;
    exp_route[1] = c >= 6'h32;
    exp_route[0] = c[5:4] == 2'b10;
  endfunction
  task automatic chk(string name, logic [35:0] exp, logic [35:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clk_sys);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_sfr_wr <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge i_clk_sys);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_sfr_rd <= 1'b0;
    #1;
    chk("read data", exp, o_sfr_rdata);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    logic [7:0] d;
    logic [2:0] q;
    int n;
    repeat (4) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    #1;
    chk("reset ground", 1, o_ground_select);
    chk("reset hiz", 1, o_temp_sensor_hiz);
    chk("reset ref pin", 1, o_ref_from_pin);
    rd(`AIR_CHAN_SEL_ADDR, 8'h3F);
    rd(`AIR_REF_CTRL_ADDR, 8'h00);
    // Pin setup lies outside this bank.
    for (int c = 0; c < 64; c++)
    begin
      d = 8'(next_rand());
      d[5:0] = 6'(c);
      n = chg_count;
      wr(`AIR_CHAN_SEL_ADDR, d);
      chk("channel change", 1, chg_count - n);
      chk("route", exp_route(d[5:0]), {o_pin_select, o_temp_select,
        o_supply_select, o_ground_select, o_select_invalid});
      rd(`AIR_CHAN_SEL_ADDR, {2'b00, d[5:0]});
    end
    n = chg_count;
    wr(8'h00, 8'h30);
    chk("channel change", 0, chg_count - n);
    rd(`AIR_CHAN_SEL_ADDR, 8'h3F);
    rd(8'h00, 8'h00);
    n = chg_count;
    wr(`AIR_CHAN_SEL_ADDR, 8'hFF);
    chk("channel change", 0, chg_count - n);
    wr(`AIR_CHAN_SEL_ADDR, 8'h30);
    for (int i = 0; i < 24; i++)
    begin
      d = i < 2 ? {8{i[0]}} : 8'(next_rand());
      q = i < 2 ? 3'b000 : 3'(next_rand());
      @(posedge i_clk_sys);
      {i_conv_enable, i_osc_bias_req, i_periph_bias_req} <= q;
      wr(`AIR_REF_CTRL_ADDR, d);
      chk("sensor on", d[2], o_temp_sensor_on);
      chk("sensor hiz", !d[2], o_temp_sensor_hiz);
      chk("temp invalid", !d[2], o_temp_reading_invalid);
      chk("ref supply", d[3], o_ref_from_supply);
      chk("ref pin", !d[3], o_ref_from_pin);
      chk("ref buffer", d[0], o_ref_buffer_drive);
      chk("bias", d[1] | d[2] | (|q), o_bias_on);
      rd(`AIR_REF_CTRL_ADDR, d & 8'h0F);
    end
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    rd(`AIR_CHAN_SEL_ADDR, 8'h3F);
    rd(`AIR_REF_CTRL_ADDR, 8'h00);
    chk("reset ground", 1, o_ground_select);
    chk("reset ref pin", 1, o_ref_from_pin);
    summarize();
  end
endmodule // tb
bind air_ctrl_top air_ctrl_sva i_sva (.*);
